// ### design/hbc_cfg.svh
/*
 * Constants of the half-bridge fault and reset controller: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 20 MHz system clock; included by bare name.
 */
`ifndef HBC_CFG_SVH
`define HBC_CFG_SVH

// ***********************************************
// Timing
// ***********************************************
`define HBC_CLK_PERIOD_NS 50
`define HBC_MIN_LOW_NS 100
`define HBC_MIN_LOW_CYC ((`HBC_MIN_LOW_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)
`define HBC_RST_PULSE_NS 1000
`define HBC_RST_PULSE_CYC ((`HBC_RST_PULSE_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)
`define HBC_MIN_HIGH_CYC 1
`define HBC_PWM_PERIOD_CYC 1000

// ***********************************************
// Register word offsets
// ***********************************************
`define HBC_REG_CTRL 4'h0
`define HBC_REG_STATUS 4'h1
`define HBC_REG_MASK 4'h2
`define HBC_REG_LEVEL 4'h3
`define HBC_REG_CLEAR 4'h4
`define HBC_REG_DUTY0 4'h5

// ***********************************************
// Fields
// ***********************************************
`define HBC_CTRL_ENABLE 0
`define HBC_CTRL_LATCHED 1
`define HBC_CTRL_TWO_QUAD 2
`define HBC_EV_FAULT_SET 0
`define HBC_EV_FAULT_CLR 1
`define HBC_EV_WARN 2
`define HBC_LVL_FAULT_N 0
`define HBC_LVL_WARN_N 1
`define HBC_LVL_BUSY 2
`define HBC_LVL_RST_LSB 4
`define HBC_CTRL_RESET 3'h0
`define HBC_MASK_RESET 3'h0
`define HBC_DUTY_RESET 16'h01f4

`endif

// ### design/hbc_pkg.sv
/*
 * Types of the half-bridge fault and reset controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package hbc_pkg;
   typedef enum logic [2:0] {
      ST_HOLD  = 3'b001,
      ST_RUN   = 3'b010,
      ST_PULSE = 3'b100
   } hbc_state_t;
endpackage
`default_nettype wire

// ### design/hbc_pwm.sv
/*
 * Three-phase complementary PWM generator with a shared period counter.
 * Assumes duty words from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hbc_cfg.svh"

module hbc_pwm #(
   parameter int PERIOD = `HBC_PWM_PERIOD_CYC,
   parameter int MIN_LO = `HBC_MIN_LOW_CYC,
   parameter int MIN_HI = `HBC_MIN_HIGH_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [47:0] duty,
   output logic [2:0] pwm_q
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [2:0] pwm_d;
   localparam logic [15:0] LAST = 16'(PERIOD - 1);
   localparam logic [15:0] HI_LIM = 16'(PERIOD - MIN_LO);
   localparam logic [15:0] LO_LIM = 16'(MIN_HI);

   always_comb begin
      cnt_d = (cnt_q == LAST) ? 16'h0000 : cnt_q + 16'h0001;
   end

   // ***********************************************
   // Per-phase compare
   // ***********************************************
   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_ph
         logic [15:0] dc;
         // Clamping keeps the input toggling every period, so no phase
         // can stay parked in high impedance after a limiting event.
         always_comb begin
            dc = duty[16*i +: 16];
            if (dc > HI_LIM) begin
               dc = HI_LIM;
            end else if (dc < LO_LIM) begin
               dc = LO_LIM;
            end
            pwm_d[i] = cnt_d < dc;
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= 16'h0000;
         pwm_q <= 3'h0;
      end else begin
         cnt_q <= cnt_d;
         pwm_q <= pwm_d;
      end
   end

   a_low_pulse_min: assert property (@(posedge clk) disable iff (srst)
      $fell(pwm_q[0]) |-> !pwm_q[0] [*2])
      else $error("low-side pulse shorter than minimum");
   a_pwm_toggles: assert property (@(posedge clk) disable iff (srst)
      (cnt_q == 16'h0000) |-> ##[1:1000] !pwm_q[1])
      else $error("phase input held constant for a period");
endmodule
`default_nettype wire

// ### design/hbc_top.sv
/*
 * Host-side controller for a three-half-bridge power stage: PWM,
 * per-phase active-low resets, overcurrent mode pin, fault and
 * thermal warning monitoring, Avalon-MM slave registers and interrupt.
 * Assumes fault_n and thermal_warning_n arrive asynchronously.
 */
// Summary of operation
// - Latched/thermal: all three resets must rise (sequencer pulses all three in latched mode only)
// - Drive phases with complementary switching
// - Low-side on-pulse at least 100 ns
// - Two-quadrant use forces latched mode
// - Keep inputs toggling after limiting events
`timescale 1ns/1ps
`default_nettype none
`include "hbc_cfg.svh"

module hbc_top #(
   parameter int PERIOD = `HBC_PWM_PERIOD_CYC,
   parameter int RST_CYC = `HBC_RST_PULSE_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata_q,
   output logic avs_waitrequest_q,
   output logic irq_q,
   output logic [2:0] pwm_q,
   output logic [2:0] reset_n_q,
   output logic latched_overcurrent_mode_q,
   input wire logic fault_n,
   input wire logic thermal_warning_n
);
   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   logic [1:0] in_s1_q;
   logic [1:0] in_s2_q;
   logic [1:0] in_s3_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         in_s1_q <= 2'h3;
         in_s2_q <= 2'h3;
         in_s3_q <= 2'h3;
      end else begin
         in_s1_q <= {thermal_warning_n, fault_n};
         in_s2_q <= in_s1_q;
         in_s3_q <= in_s2_q;
      end
   end
   logic [2:0] ev;
   // Fault low covers undervoltage, overcurrent and thermal shutdown
   assign ev[`HBC_EV_FAULT_SET] = in_s3_q[0] & ~in_s2_q[0];
   // Undervoltage clears by itself, so a release can come unasked
   assign ev[`HBC_EV_FAULT_CLR] = ~in_s3_q[0] & in_s2_q[0];
   assign ev[`HBC_EV_WARN] = in_s3_q[1] & ~in_s2_q[1];

   // ***********************************************
   // Avalon-MM slave
   // ***********************************************
   logic req;
   logic take;
   logic [2:0] ctrl_q, ctrl_d;
   logic [2:0] stat_q, stat_d;
   logic [2:0] mask_q, mask_d;
   logic [47:0] duty_q, duty_d;
   logic [31:0] rdata_d;
   logic wait_d;
   logic irq_d;
   logic clr_go;
   logic [2:0] clr_sel;
   hbc_pkg::hbc_state_t st_q, st_d;
   logic [15:0] cnt_q, cnt_d;
   logic [2:0] pmask_q, pmask_d;
   logic [2:0] rst_d;
   logic mode_d;

   assign req = avs_read | avs_write;
   // One wait cycle: access completes at the edge that sees wait low
   assign take = req & ~avs_waitrequest_q;
   assign clr_go = take & avs_write & (avs_address == `HBC_REG_CLEAR);
   assign clr_sel = avs_writedata[2:0];

   always_comb begin
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      duty_d = duty_q;
      wait_d = ~(req & avs_waitrequest_q);
      rdata_d = avs_readdata_q;
      // Set wins over a simultaneous write-one clear
      stat_d = stat_q & ~((take & avs_write & (avs_address == `HBC_REG_STATUS))
                          ? avs_writedata[2:0] : 3'h0);
      stat_d = stat_d | ev;
      if (take && avs_write) begin
         case (avs_address)
            `HBC_REG_CTRL: ctrl_d = avs_writedata[2:0];
            `HBC_REG_MASK: mask_d = avs_writedata[2:0];
            4'h5, 4'h6, 4'h7: duty_d[16*(avs_address - 4'h5) +: 16] = avs_writedata[15:0];
            default: ;
         endcase
      end
      if (req && avs_waitrequest_q) begin
         case (avs_address)
            `HBC_REG_CTRL: rdata_d = {29'h0, ctrl_q};
            `HBC_REG_STATUS: rdata_d = {29'h0, stat_q};
            `HBC_REG_MASK: rdata_d = {29'h0, mask_q};
            `HBC_REG_LEVEL: rdata_d = {25'h0, reset_n_q, 1'b0, (st_q != hbc_pkg::ST_RUN),
                                       in_s2_q};
            4'h5: rdata_d = {16'h0, duty_q[15:0]};
            4'h6: rdata_d = {16'h0, duty_q[31:16]};
            4'h7: rdata_d = {16'h0, duty_q[47:32]};
            default: rdata_d = 32'h0;
         endcase
      end
      irq_d = |(stat_d & mask_d);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_q <= `HBC_CTRL_RESET;
         mask_q <= `HBC_MASK_RESET;
         stat_q <= 3'h0;
         duty_q <= {3{`HBC_DUTY_RESET}};
         avs_waitrequest_q <= 1'b1;
         avs_readdata_q <= 32'h0;
         irq_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         duty_q <= duty_d;
         avs_waitrequest_q <= wait_d;
         avs_readdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   // ***********************************************
   // Reset sequencer
   // ***********************************************
   localparam logic [15:0] RST_LAST = 16'(RST_CYC - 1);
   logic latched_sel;
   // Two-quadrant use must not run cycle limiting
   assign latched_sel = ctrl_q[`HBC_CTRL_LATCHED] | ctrl_q[`HBC_CTRL_TWO_QUAD];

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      pmask_d = pmask_q;
      case (st_q)
         hbc_pkg::ST_HOLD: begin
            // Release only once the mode pin already shows the wanted mode
            if (ctrl_q[`HBC_CTRL_ENABLE] && latched_overcurrent_mode_q == latched_sel) begin
               st_d = hbc_pkg::ST_RUN;
            end
         end
         hbc_pkg::ST_RUN: begin
            if (!ctrl_q[`HBC_CTRL_ENABLE]) begin
               st_d = hbc_pkg::ST_HOLD;
            end else if (clr_go && clr_sel != 3'h0) begin
               st_d = hbc_pkg::ST_PULSE;
               cnt_d = 16'h0000;
               // Latched faults need a rising edge on every phase
               pmask_d = latched_sel ? 3'h7 : clr_sel;
            end
         end
         hbc_pkg::ST_PULSE: begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_q == RST_LAST) begin
               st_d = ctrl_q[`HBC_CTRL_ENABLE] ? hbc_pkg::ST_RUN : hbc_pkg::ST_HOLD;
            end
         end
         default: st_d = hbc_pkg::ST_HOLD;
      endcase
      // Disabled bridges float; a pulse gives its phase a rising edge
      rst_d = 3'h7;
      if (st_d == hbc_pkg::ST_HOLD) begin
         rst_d = 3'h0;
      end else if (st_d == hbc_pkg::ST_PULSE) begin
         rst_d = ~pmask_d;
      end
      // Mode pin changes only with all bridges held in reset
      if (st_q == hbc_pkg::ST_HOLD && st_d == hbc_pkg::ST_HOLD) begin
         mode_d = latched_sel;
      end else begin
         mode_d = latched_overcurrent_mode_q;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= hbc_pkg::ST_HOLD;
         cnt_q <= 16'h0000;
         pmask_q <= 3'h0;
         reset_n_q <= 3'h0;
         latched_overcurrent_mode_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         pmask_q <= pmask_d;
         reset_n_q <= rst_d;
         latched_overcurrent_mode_q <= mode_d;
      end
   end

   hbc_pwm #(
      .PERIOD(PERIOD)
   ) hbc_pwm_i (
      .clk(clk),
      .srst(srst),
      .duty(duty_q),
      .pwm_q(pwm_q)
   );

   // ***********************************************
   // Checks
   // ***********************************************
   a_hold_resets: assert property (@(posedge clk) disable iff (srst)
      (st_q == hbc_pkg::ST_HOLD) |-> reset_n_q == 3'h0)
      else $error("resets not held low while disabled");
   a_latched_all: assert property (@(posedge clk) disable iff (srst)
      (clr_go && clr_sel != 3'h0 && st_q == hbc_pkg::ST_RUN && latched_sel)
      |=> reset_n_q == 3'h0)
      else $error("latched clear did not pulse all resets");
   a_cycle_one: assert property (@(posedge clk) disable iff (srst)
      (clr_go && st_q == hbc_pkg::ST_RUN && !latched_sel && ctrl_q[0] && clr_sel != 3'h0)
      |=> reset_n_q == ~$past(clr_sel))
      else $error("cycle clear hit wrong phases");
   a_pulse_ends: assert property (@(posedge clk) disable iff (srst)
      $rose(st_q == hbc_pkg::ST_PULSE) |-> ##[1:300] st_q != hbc_pkg::ST_PULSE)
      else $error("reset pulse did not end");
   a_two_quad: assert property (@(posedge clk) disable iff (srst)
      (st_q == hbc_pkg::ST_HOLD && ctrl_q[`HBC_CTRL_TWO_QUAD]) |=> latched_overcurrent_mode_q)
      else $error("two-quadrant use left cycle limiting on");
   a_fault_flag: assert property (@(posedge clk) disable iff (srst)
      (in_s3_q[0] && !in_s2_q[0]) |=> stat_q[`HBC_EV_FAULT_SET])
      else $error("fault event not recorded");
   a_fault_release: assert property (@(posedge clk) disable iff (srst)
      $rose(in_s2_q[0]) |=> stat_q[`HBC_EV_FAULT_CLR])
      else $error("fault release not recorded");
   a_wait_one: assert property (@(posedge clk) disable iff (srst)
      (req && avs_waitrequest_q) |=> !avs_waitrequest_q)
      else $error("bus answer late");
endmodule
`default_nettype wire

// ### testbench/half_bridge_fault_reset_control_test.sv
/*
 * Self-checking bench of the controller against the stage model.
 * Assumes the register map and latencies of the configuration header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hbc_cfg.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

module half_bridge_fault_reset_control_test;
   localparam int PER = 20;
   localparam int RC = 4;
   logic clk = 0, srst = 1, avs_read = 0, avs_write = 0, uv = 0, ot = 0, hot = 0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata_q, rd;
   logic avs_waitrequest_q, irq_q, latched_overcurrent_mode_q, fault_n, thermal_warning_n;
   logic [2:0] pwm_q, reset_n_q, hiz, oc = 3'h0, lim = 3'h0;
   int bad_count = 0, cmp_count = 0, n;
   int h[3];

   initial forever #25 clk = ~clk;

   hbc_top #(.PERIOD(PER), .RST_CYC(RC)) hbc_top_i (.clk(clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata_q(avs_readdata_q),
      .avs_waitrequest_q(avs_waitrequest_q), .irq_q(irq_q), .pwm_q(pwm_q),
      .reset_n_q(reset_n_q), .latched_overcurrent_mode_q(latched_overcurrent_mode_q),
      .fault_n(fault_n), .thermal_warning_n(thermal_warning_n));
   hbc_dev_model hbc_dev_model_i (.reset_n(reset_n_q), .latched(latched_overcurrent_mode_q),
      .uv(uv), .oc(oc), .ot(ot), .hot(hot), .pwm(pwm_q), .lim(lim), .fault_n(fault_n),
      .thermal_warning_n(thermal_warning_n), .hiz(hiz));

   task automatic summarize;
      $display("counts: %0d compared, %0d bad", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Entered just after a rising edge; returns one edge after release
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int k;
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= ~wr;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest_q !== 1'b0 && k < 20);
      rd = avs_readdata_q;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k >= 20) begin
         bad_count++;
         summarize();
      end
      @(posedge clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask

   task automatic wt(input int c);
      repeat (c) @(posedge clk);
   endtask

   // Length of the next low pulse on one reset line
   task automatic plen(input int ph, output int len);
      int k;
      k = 0;
      len = 0;
      while (reset_n_q[ph] !== 1'b0 && k < 20) begin
         @(posedge clk);
         k++;
      end
      while (reset_n_q[ph] === 1'b0 && len < 50) begin
         @(posedge clk);
         len++;
      end
      if (k >= 20 || len >= 50) begin
         bad_count++;
         summarize();
      end
   endtask

   initial begin
      #1000000;
      bad_count++;
      summarize();
   end

   initial begin
      wt(5);
      srst <= 1'b0;
      wt(1);
      `CHK("reset_n", 3'h0, reset_n_q)
      `CHK("hiz", 3'h7, hiz)
      `CHK("irq", 1'b0, irq_q)
      rdchk(`HBC_REG_LEVEL, 32'h7, "level");
      rdchk(`HBC_REG_CTRL, 32'h0, "ctrl");
      rdchk(`HBC_REG_DUTY0, 32'h1f4, "duty");
      rdchk(4'h9, 32'h0, "unmapped");
      wr(`HBC_REG_MASK, 32'h7);
      wr(`HBC_REG_CTRL, 32'h1);
      wt(2);
      `CHK("reset_n", 3'h7, reset_n_q)
      `CHK("hiz", 3'h0, hiz)
      `CHK("mode", 1'b0, latched_overcurrent_mode_q)
      uv <= 1'b1;
      wt(6);
      `CHK("irq", 1'b1, irq_q)
      `CHK("hiz", 3'h7, hiz)
      rdchk(`HBC_REG_LEVEL, 32'h72, "level");
      uv <= 1'b0;
      wt(6);
      rdchk(`HBC_REG_STATUS, 32'h3, "status");
      wr(`HBC_REG_STATUS, 32'h3);
      wt(2);
      `CHK("irq", 1'b0, irq_q)
      // Cycle mode: only the tripped phase needs its reset edge
      oc <= 3'h2;
      wt(6);
      oc <= 3'h0;
      rdchk(`HBC_REG_LEVEL, 32'h72, "level");
      fork
         wr(`HBC_REG_CLEAR, 32'h2);
         plen(1, n);
      join
      `CHK("pulse", RC, n)
      wt(6);
      rdchk(`HBC_REG_LEVEL, 32'h73, "level");
      // Limiting on phase B must end once its input toggles again
      lim <= 3'h2;
      wt(2);
      `CHK("hiz", 3'h2, hiz)
      lim <= 3'h0;
      wt(PER + 2);
      `CHK("hiz", 3'h0, hiz)
      wr(`HBC_REG_CTRL, 32'h0);
      wr(`HBC_REG_CTRL, 32'h5);
      wt(2);
      `CHK("mode", 1'b1, latched_overcurrent_mode_q)
      wr(`HBC_REG_CTRL, 32'h0);
      wr(`HBC_REG_CTRL, 32'h3);
      wt(2);
      `CHK("mode", 1'b1, latched_overcurrent_mode_q)
      ot <= 1'b1;
      wt(6);
      ot <= 1'b0;
      wr(`HBC_REG_STATUS, 32'h7);
      fork
         wr(`HBC_REG_CLEAR, 32'h1);
         plen(2, n);
      join
      `CHK("pulse", RC, n)
      wt(6);
      rdchk(`HBC_REG_LEVEL, 32'h73, "level");
      wr(`HBC_REG_STATUS, 32'h7);
      wr(`HBC_REG_MASK, 32'h3);
      hot <= 1'b1;
      wt(6);
      `CHK("irq", 1'b0, irq_q)
      rdchk(`HBC_REG_STATUS, 32'h4, "status");
      wr(`HBC_REG_MASK, 32'h7);
      wt(2);
      `CHK("irq", 1'b1, irq_q)
      hot <= 1'b0;
      wr(`HBC_REG_STATUS, 32'h4);
      wt(2);
      `CHK("irq", 1'b0, irq_q)
      wr(`HBC_REG_DUTY0, 32'hffff);
      wr(`HBC_REG_DUTY0 + 4'h1, 32'h0);
      wr(`HBC_REG_DUTY0 + 4'h2, 32'ha);
      wt(2 * PER);
      h = '{0, 0, 0};
      for (int i = 0; i < PER; i++) begin
         @(posedge clk);
         for (int j = 0; j < 3; j++) h[j] += int'(pwm_q[j] === 1'b1);
      end
      `CHK("high_a", PER - 2, h[0])
      `CHK("high_b", 1, h[1])
      `CHK("high_c", 10, h[2])
      summarize();
   end
endmodule

`default_nettype wire

// ### testbench/hbc_dev_model.sv
/*
 * Behavioural model of the three-half-bridge power stage.
 * Assumes the bench raises supply, overcurrent and heat events.
 */
`timescale 1ns/1ps
`default_nettype none

module hbc_dev_model (
   input wire logic [2:0] reset_n,
   input wire logic latched,
   input wire logic uv,
   input wire logic [2:0] oc,
   input wire logic ot,
   input wire logic hot,
   input wire logic [2:0] pwm,
   input wire logic [2:0] lim,
   output logic fault_n,
   output logic thermal_warning_n,
   output logic [2:0] hiz
);
   logic [2:0] oc_lat = 3'h0;
   logic [2:0] rose = 3'h0;
   logic ot_lat = 1'b0;
   logic [2:0] lim_q = 3'h0;

   always @(posedge ot) begin
      ot_lat = 1'b1;
      rose = 3'h0;
   end

   for (genvar i = 0; i < 3; i++) begin : g_ph
      always @(posedge oc[i]) begin
         oc_lat[i] = 1'b1;
         rose = 3'h0;
      end
      // In cycle mode a limiting event leaves the phase floating until its input rises
      always @(negedge lim[i]) begin
         if (!latched) lim_q[i] = 1'b1;
      end
      always @(posedge pwm[i]) begin
         lim_q[i] = 1'b0;
      end
      always @(posedge reset_n[i]) begin
         if (!latched) oc_lat[i] = 1'b0;
         rose[i] = 1'b1;
         // Thermal and latched-mode overcurrent latches clear only once every phase has risen
         if (&rose) begin
            ot_lat = 1'b0;
            if (latched) oc_lat = 3'h0;
            rose = 3'h0;
         end
      end
   end

   assign hiz = ~reset_n | {3{uv | ot_lat}} | oc_lat | lim_q | (lim & {3{~latched}});
   assign fault_n = ~(uv | ot_lat | (|oc_lat));
   assign thermal_warning_n = ~hot;
endmodule

`default_nettype wire
